/* File: hw/tac_pkg.sv */
// Purpose: Shared constants and types for the touch acquisition control.
// Assumes: One 10 MHz clock, synchronous active-high reset.
// Notes:   Long counts are scaled by one-millisecond tick enables.
package tac_pkg;

  // ==========================================================================
  // Clock and timing
  // ==========================================================================
  localparam int CLK_HZ        = 10000000;
  localparam int TICK_US       = 1000;
  localparam int TICK_CYCLES   = CLK_HZ / 1000000 * TICK_US;
  localparam int BOOT_MS       = 48;
  localparam int ACQ_LINE_MS   = 2;
  localparam int ACQ_TOTAL_MS  = 250;

  // ==========================================================================
  // Widths and sizes
  // ==========================================================================
  localparam int NSENS         = 8;
  localparam int INTW          = 8;
  localparam int SIGW          = 12;
  localparam int POSW          = 8;
  localparam int MSW           = 8;

  // ==========================================================================
  // Reset values
  // ==========================================================================
  localparam logic [INTW-1:0] INTEG_RST = 8'h00;

  typedef enum logic [1:0] {
    TAC_SLEEP,
    TAC_BURST
  } tac_phase_type;

endpackage

/* File: hw/tac_sens_if.sv */
// Purpose: Carries per-acquisition sensor data to the integrator.
// Assumes: Signals are sampled on mclk.
// Notes:   One vector bit per sensor.
`timescale 1ns/1ps
interface tac_sens_if;
  import tac_pkg::*;
  logic                     acq_done;
  logic                     clear;
  logic [NSENS-1:0]         above;
  logic [INTW-1:0]          limit;
  logic [NSENS-1:0]         touched;
  modport ctrl (output acq_done, output clear, output above, output limit,
                input touched);
  modport integ (input acq_done, input clear, input above, input limit,
                 output touched);
endinterface

/* File: hw/tac_integrator.sv */
// Purpose: Per-sensor detection integrator.
// Assumes: acq_done pulses once per finished acquisition.
// Notes:   Counters saturate at the limit so touch stays latched.
`timescale 1ns/1ps
module tac_integrator (
  input wire logic mclk,
  input wire logic rst,
  tac_sens_if.integ s
);
  import tac_pkg::*;

  // ==========================================================================
  // Counters
  // ==========================================================================
  logic [INTW-1:0] count      [NSENS];
  logic [INTW-1:0] next_count [NSENS];

  genvar g;
  generate
    for (g = 0; g < NSENS; g++) begin : g_sens
      // Count up while above threshold, restart on any miss.
      always_comb begin
        next_count[g] = count[g];
        if (s.clear) begin
          next_count[g] = INTEG_RST;
        end else if (s.acq_done) begin
          if (!s.above[g]) begin
            next_count[g] = INTEG_RST;
          end else if (count[g] < s.limit) begin
            next_count[g] = count[g] + 8'h01;
          end
        end
      end

      // Register only.
      always_ff @(posedge mclk) begin
        if (rst) begin
          count[g] <= INTEG_RST;
        end else begin
          count[g] <= next_count[g];
        end
      end

      // Touched once the limit is reached; a zero limit never declares.
      assign s.touched[g] = (s.limit != INTEG_RST) &&
                            (count[g] >= s.limit);
    end
  endgenerate

endmodule // tac_integrator

/* File: hw/tac_ctrl.sv */
// Purpose: Boot notice, burst scheduling, integration, calibration,
//          noise, moisture and grip control of a touch controller.
// Assumes: Analog front end supplies per-sensor mutual signal levels and self touch results.
// Notes:   Intervals are in milliseconds of the internal tick.
// Behaviour
// - After boot, pull message line low
// - Active or idle, bursts then sleep
// - Cycle lengths from idle/active intervals
// - Count acquisitions above threshold
// - Touched when count reaches limit
// - Clear count when below threshold
// - Report signal error on acquisition timeout
// - Recalibrate on any calibration trigger
// - Noise suppression on host or measured noise
// - Prefer mutual data, self fills gaps
// - Moisture from both; then self single touch
// - Suppress touches in edge band
// - Assert message line after reset (code keeps it released until the 48 ms boot count ends)
`timescale 1ns/1ps
module tac_ctrl (
  input  wire logic                         mclk,
  input  wire logic                         rst,
  input  wire logic [tac_pkg::MSW-1:0]      idle_cycle_interval,
  input  wire logic [tac_pkg::MSW-1:0]      active_cycle_interval,
  input  wire logic [tac_pkg::MSW-1:0]      active_idle_timeout,
  input  wire logic [tac_pkg::INTW-1:0]     integ_limit,
  input  wire logic [tac_pkg::SIGW-1:0]     touch_threshold,
  input  wire logic [tac_pkg::NSENS*tac_pkg::SIGW-1:0] mutual_signal,
  input  wire logic [tac_pkg::NSENS-1:0]    self_touch,
  input  wire logic                         self_enable,
  input  wire logic                         moisture_comp_enable,
  input  wire logic                         mutual_moisture,
  input  wire logic                         self_moisture,
  input  wire logic                         acq_line_done,
  input  wire logic                         acq_end,
  input  wire logic                         host_recal,
  input  wire logic                         self_tune,
  input  wire logic                         mutual_recal_req,
  input  wire logic                         self_recal_req,
  input  wire logic                         config_changed,
  input  wire logic                         host_noise,
  input  wire logic                         line_noise,
  input  wire logic [tac_pkg::POSW-1:0]     touch_x,
  input  wire logic [tac_pkg::POSW-1:0]     touch_y,
  input  wire logic [tac_pkg::POSW-1:0]     screen_x_max,
  input  wire logic [tac_pkg::POSW-1:0]     screen_y_max,
  input  wire logic [tac_pkg::POSW-1:0]     grip_band,
  input  wire logic                         message_read,
  output logic                              message_pending_line_n,
  output logic                              message_pending_oe,
  output logic                              active_mode,
  output logic                              burst_on,
  output logic                              signal_error_flag,
  output logic                              recalibrate,
  output logic                              noise_suppress,
  output logic                              moisture_present,
  output logic                              use_self_single,
  output logic [tac_pkg::NSENS-1:0]         touched,
  output logic                              report_touch
);
  import tac_pkg::*;

  // ==========================================================================
  // Millisecond tick
  // ==========================================================================
  logic [15:0] tick_cnt, next_tick_cnt;
  logic        tick;

  // A single divider keeps every slow count on one clock.
  always_comb begin
    next_tick_cnt = tick_cnt + 16'h0001;
    if (tick_cnt == 16'(TICK_CYCLES - 1)) begin
      next_tick_cnt = 16'h0000;
    end
  end
  assign tick = (tick_cnt == 16'(TICK_CYCLES - 1));

  always_ff @(posedge mclk) begin
    if (rst) begin
      tick_cnt <= 16'h0000;
    end else begin
      tick_cnt <= next_tick_cnt;
    end
  end

  // ==========================================================================
  // Boot and message line
  // ==========================================================================
  logic [MSW-1:0] boot_ms, next_boot_ms;
  logic           booted, next_booted;
  logic           pend, next_pend;
  logic           signal_error_flag_set;
  logic           mode_change;
  logic [NSENS-1:0] touched_int;
  logic           recal_now;

  // Line stays released (input) during boot, then low shows a message.
  always_comb begin
    next_boot_ms = boot_ms;
    next_booted  = booted;
    next_pend    = pend;
    if (!booted && tick) begin
      next_boot_ms = boot_ms + 8'h01;
      if (boot_ms == 8'(BOOT_MS - 1)) begin
        next_booted = 1'b1;
        next_pend   = 1'b1;
      end
    end else if (booted && message_read) begin
      next_pend = 1'b0;
    end
    if (booted && (signal_error_flag_set || mode_change)) begin
      next_pend = 1'b1; // Set wins over the host's read.
    end
  end

  // ==========================================================================
  // Burst scheduling
  // ==========================================================================
  logic [MSW-1:0] cyc_ms, next_cyc_ms;
  logic [MSW-1:0] quiet_ms, next_quiet_ms;
  logic           act, next_act;
  logic           any_touch;
  logic [MSW-1:0] cyc_len;

  assign any_touch = |touched_int;
  assign cyc_len   = act ? active_cycle_interval : idle_cycle_interval;
  assign mode_change = (next_act != act);

  // Bursts open each cycle; the front end ends them with acq_end.
  always_comb begin
    next_cyc_ms   = cyc_ms;
    next_quiet_ms = quiet_ms;
    next_act      = act;
    if (booted && tick) begin
      next_cyc_ms = (cyc_ms + 8'h01 >= cyc_len) ? 8'h00 : cyc_ms + 8'h01;
    end
    if (any_touch) begin
      next_act      = 1'b1;
      next_quiet_ms = 8'h00;
    end else if (act && tick) begin
      next_quiet_ms = quiet_ms + 8'h01;
      if (quiet_ms + 8'h01 >= active_idle_timeout) begin
        next_act      = 1'b0;
        next_quiet_ms = 8'h00;
      end
    end
  end

  tac_phase_type phase, next_phase;
  logic [MSW-1:0] acq_ms, next_acq_ms;
  logic [MSW-1:0] line_ms, next_line_ms;

  // Burst then sleep, repeating in either mode.
  always_comb begin
    next_phase   = phase;
    next_acq_ms  = acq_ms;
    next_line_ms = line_ms;
    signal_error_flag_set = 1'b0;
    case (phase)
      TAC_SLEEP: begin
        if (booted && tick && cyc_ms == 8'h00) begin
          next_phase   = TAC_BURST;
          next_acq_ms  = 8'h00;
          next_line_ms = 8'h00;
        end
      end
      TAC_BURST: begin
        if (tick) begin
          next_acq_ms  = acq_ms + 8'h01;
          next_line_ms = line_ms + 8'h01;
        end
        if (acq_line_done) begin
          next_line_ms = 8'h00;
        end
        if (acq_end) begin
          next_phase = TAC_SLEEP;
        end else if (acq_ms >= 8'(ACQ_TOTAL_MS) ||
                     line_ms >= 8'(ACQ_LINE_MS)) begin
          signal_error_flag_set = 1'b1;
          next_phase = TAC_SLEEP;
        end
      end
      default: next_phase = TAC_SLEEP;
    endcase
  end

  // ==========================================================================
  // Integrator
  // ==========================================================================
  tac_sens_if sif ();
  logic [NSENS-1:0] above;

  genvar g;
  generate
    for (g = 0; g < NSENS; g++) begin : g_th
      // Mutual first; self only fills in when enabled.
      assign above[g] = (mutual_signal[g*SIGW +: SIGW] > touch_threshold) ||
                        (self_enable && self_touch[g]);
    end
  endgenerate

  assign sif.acq_done = (phase == TAC_BURST) && acq_end;
  assign sif.clear    = recal_now;
  assign sif.above    = above;
  assign sif.limit    = integ_limit;
  assign touched_int  = sif.touched;

  tac_integrator u_integ (
    .mclk (mclk),
    .rst  (rst),
    .s    (sif)
  );

  // ==========================================================================
  // Calibration, noise, moisture, grip
  // ==========================================================================
  logic moist, next_moist;
  logic grip_hit;

  assign recal_now = host_recal || self_tune || mutual_recal_req ||
                     self_recal_req || config_changed ||
                     (moist && !next_moist);

  // Moisture needs both data types, so self scheduling is required.
  always_comb begin
    next_moist = 1'b0;
    if (moisture_comp_enable && self_enable) begin
      next_moist = mutual_moisture || self_moisture;
    end
  end

  // Edge band hides grip touches but keeps the centre live.
  assign grip_hit = (touch_x < grip_band) || (touch_y < grip_band) ||
                    (touch_x > screen_x_max - grip_band) ||
                    (touch_y > screen_y_max - grip_band);

  // ==========================================================================
  // State registers
  // ==========================================================================
  always_ff @(posedge mclk) begin
    if (rst) begin
      boot_ms  <= 8'h00;
      booted   <= 1'b0;
      pend     <= 1'b0;
      cyc_ms   <= 8'h00;
      quiet_ms <= 8'h00;
      act      <= 1'b0;
      phase    <= TAC_SLEEP;
      acq_ms   <= 8'h00;
      line_ms  <= 8'h00;
      moist    <= 1'b0;
    end else begin
      boot_ms  <= next_boot_ms;
      booted   <= next_booted;
      pend     <= next_pend;
      cyc_ms   <= next_cyc_ms;
      quiet_ms <= next_quiet_ms;
      act      <= next_act;
      phase    <= next_phase;
      acq_ms   <= next_acq_ms;
      line_ms  <= next_line_ms;
      moist    <= next_moist;
    end
  end

  // Outputs straight from flip-flops.
  always_ff @(posedge mclk) begin
    if (rst) begin
      message_pending_line_n <= 1'b0;
      message_pending_oe     <= 1'b0;
      active_mode            <= 1'b0;
      burst_on               <= 1'b0;
      signal_error_flag      <= 1'b0;
      recalibrate            <= 1'b0;
      noise_suppress         <= 1'b0;
      moisture_present       <= 1'b0;
      use_self_single        <= 1'b0;
      touched                <= '0;
      report_touch           <= 1'b0;
    end else begin
      message_pending_line_n <= 1'b0;
      message_pending_oe     <= next_pend;
      active_mode            <= next_act;
      burst_on               <= (next_phase == TAC_BURST);
      if (signal_error_flag_set) begin
        signal_error_flag <= 1'b1;
      end else if (message_read) begin
        signal_error_flag <= 1'b0;
      end
      recalibrate            <= recal_now;
      noise_suppress         <= host_noise || line_noise;
      moisture_present       <= next_moist;
      use_self_single        <= next_moist;
      touched                <= touched_int;
      report_touch           <= any_touch && !grip_hit;
    end
  end

endmodule // tac_ctrl

/* File: sim/tac_ctrl_properties.sv */
// Purpose: Port-level properties of the acquisition control.
// Assumes: One clock, synchronous active-high reset.
// Notes:   Boot delay is timed on a saturating cycle counter.
`timescale 1ns/1ps
module tac_ctrl_properties
  import tac_pkg::*;
(
  input wire logic                    mclk,
  input wire logic                    rst,
  input wire logic                    host_recal,
  input wire logic                    self_tune,
  input wire logic                    mutual_recal_req,
  input wire logic                    self_recal_req,
  input wire logic                    config_changed,
  input wire logic                    host_noise,
  input wire logic                    line_noise,
  input wire logic                    acq_end,
  input wire logic                    message_read,
  input wire logic [tac_pkg::POSW-1:0] touch_x,
  input wire logic [tac_pkg::POSW-1:0] grip_band,
  input wire logic                    message_pending_line_n,
  input wire logic                    message_pending_oe,
  input wire logic                    burst_on,
  input wire logic                    signal_error_flag,
  input wire logic                    recalibrate,
  input wire logic                    noise_suppress,
  input wire logic                    report_touch
);
  localparam int BOOT_CYC = BOOT_MS * TICK_CYCLES;
  logic [19:0] up;
  wire logic   any_recal;

  // ==========================================================================
  // Helper logic
  // ==========================================================================
  // Saturates so a long run cannot wrap back into the boot window.
  always_ff @(posedge mclk) begin
    if (rst) up <= 20'h00000;
    else if (up != 20'hfffff) up <= up + 20'h00001;
  end
  // Any one of the calibration sources.
  assign any_recal = host_recal | self_tune | mutual_recal_req |
                     self_recal_req | config_changed;

  // ==========================================================================
  // Properties
  // ==========================================================================
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);
  property p_boot_quiet; up < BOOT_CYC - 2 |-> !message_pending_oe; endproperty
  a_boot_quiet: assert property (p_boot_quiet)
    else $error("pending line pulled during boot");
  property p_line_low; message_pending_line_n == 1'b0; endproperty
  a_line_low: assert property (p_line_low)
    else $error("pending line data not low");
  property p_oe_hold; message_pending_oe && !message_read |=> message_pending_oe;
  endproperty
  a_oe_hold: assert property (p_oe_hold)
    else $error("pending line released without a read");
  property p_burst_end; acq_end && burst_on |=> !burst_on; endproperty
  a_burst_end: assert property (p_burst_end)
    else $error("burst kept after acquisition end");
  property p_err_hold; signal_error_flag && !message_read |=> signal_error_flag;
  endproperty
  a_err_hold: assert property (p_err_hold)
    else $error("error flag dropped without a read");
  property p_recal; any_recal |=> recalibrate; endproperty
  a_recal: assert property (p_recal)
    else $error("calibration trigger gave no pulse");
  property p_noise; 1'b1 |=> noise_suppress == $past(host_noise | line_noise);
  endproperty
  a_noise: assert property (p_noise)
    else $error("noise suppression not following sources");
  property p_grip; touch_x < grip_band |=> !report_touch; endproperty
  a_grip: assert property (p_grip)
    else $error("touch reported inside edge band");
endmodule // tac_ctrl_properties

bind tac_ctrl tac_ctrl_properties tac_ctrl_properties_i (
  .mclk, .rst, .host_recal, .self_tune, .mutual_recal_req, .self_recal_req,
  .config_changed, .host_noise, .line_noise, .acq_end, .message_read,
  .touch_x, .grip_band, .message_pending_line_n, .message_pending_oe,
  .burst_on, .signal_error_flag, .recalibrate, .noise_suppress, .report_touch
);

/* File: sim/tac_host_model.sv */
// Purpose: Host that watches the pending line and reads messages.
// Assumes: Line has a pull-up; device only pulls it low.
// Notes:   Reads only while the bench enables it, so levels can be seen.
`timescale 1ns/1ps
module tac_host_model (
  input  wire logic mclk,
  input  wire logic message_pending_oe,
  input  wire logic message_pending_line_n,
  input  wire logic ack_en,
  output logic      message_read
);
  wire logic line;

  // The host never drives the line; the pull-up wins when released.
  assign line = message_pending_oe ? message_pending_line_n : 1'b1;
  // One read pulse per low level; the gap stops a double read.
  always @(posedge mclk) begin
    message_read <= ack_en && !line && !message_read;
  end
endmodule // tac_host_model

/* File: sim/test_tac_ctrl.sv */
// Purpose: Self-checking bench for the acquisition control.
// Assumes: Bench answers every burst with acq_end unless told not to.
// Notes:   Boot cannot be shortened, so the run lasts about 85 ms.
`timescale 1ns/1ps
module test_tac_ctrl;
  import tac_pkg::*;
  logic mclk = 1'b0, rst = 1'b1, ack_en = 1'b0, auto = 1'b0;
  logic [MSW-1:0] idle_cycle_interval = 8'h03, active_cycle_interval = 8'h01;
  logic [MSW-1:0] active_idle_timeout = 8'h02;
  logic [INTW-1:0] integ_limit = 8'h03;
  logic [SIGW-1:0] touch_threshold = 12'h064;
  logic [NSENS*SIGW-1:0] mutual_signal = '0;
  logic [NSENS-1:0] self_touch = 8'h00, touched;
  logic self_enable = 1'b0, moisture_comp_enable = 1'b0;
  logic mutual_moisture = 1'b0, self_moisture = 1'b0, acq_end = 1'b0;
  logic acq_line_done = 1'b0, message_read;
  logic [4:0] trig = 5'h00;
  logic [1:0] nz = 2'h0;
  logic [POSW-1:0] touch_x = 8'h64, touch_y = 8'h64, grip_band = 8'h14;
  logic [POSW-1:0] screen_x_max = 8'hc8, screen_y_max = 8'hc8;
  logic message_pending_line_n, message_pending_oe, active_mode, burst_on;
  logic signal_error_flag, recalibrate, noise_suppress, moisture_present;
  logic use_self_single, report_touch;
  int cyc = 0, n_acq = 0, bad_count = 0, cmp_count = 0, n;
  wire logic host_recal = trig[0], self_tune = trig[1];
  wire logic mutual_recal_req = trig[2], self_recal_req = trig[3];
  wire logic config_changed = trig[4];
  wire logic host_noise = nz[0], line_noise = nz[1];

  // ==========================================================================
  // Clock, acquisition responder and instances
  // ==========================================================================
  always #50 mclk = ~mclk;
  // Ends bursts after one cycle, inside every limit.
  always @(posedge mclk) begin
    cyc <= cyc + 1;
    acq_end <= auto && burst_on && !acq_end;
    if (acq_end) n_acq <= n_acq + 1;
  end
  tac_ctrl tac_ctrl_i (
    .mclk, .rst, .idle_cycle_interval, .active_cycle_interval,
    .active_idle_timeout, .integ_limit, .touch_threshold, .mutual_signal,
    .self_touch, .self_enable, .moisture_comp_enable, .mutual_moisture,
    .self_moisture, .acq_line_done, .acq_end, .host_recal, .self_tune,
    .mutual_recal_req, .self_recal_req, .config_changed, .host_noise,
    .line_noise, .touch_x, .touch_y, .screen_x_max, .screen_y_max,
    .grip_band, .message_read, .message_pending_line_n, .message_pending_oe,
    .active_mode, .burst_on, .signal_error_flag, .recalibrate,
    .noise_suppress, .moisture_present, .use_self_single, .touched,
    .report_touch);
  tac_host_model tac_host_model_i (.mclk, .message_pending_oe,
    .message_pending_line_n, .ack_en, .message_read);

  // ==========================================================================
  // Shared tasks
  // ==========================================================================
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      bad_count++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // Waits for the next rising edge of burst_on, sampled mid-cycle.
  task automatic rise();
    for (int i = 0; i < 40000 && burst_on !== 1'b0; i++) @(negedge mclk);
    for (int i = 0; i < 40000 && burst_on !== 1'b1; i++) @(negedge mclk);
  endtask
  task automatic period(input int exp);
    int t;
    rise();
    t = cyc;
    rise();
    chk(cyc - t, exp);
  endtask
  // Raises sensor 0 above threshold and counts acquisitions until touch.
  task automatic integ(output int cnt);
    int a;
    a = n_acq;
    @(posedge mclk) mutual_signal[11:0] <= touch_threshold + 12'h001;
    for (int i = 0; i < 100000 && touched[0] !== 1'b1; i++) @(negedge mclk);
    cnt = n_acq - a;
  endtask
  task automatic results();
    $display("compares %0d mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  // ==========================================================================
  // Scenarios
  // ==========================================================================
  task automatic t_boot();
    int t0;
    t0 = cyc;
    chk(message_pending_oe, 1'b0);
    for (int i = 0; i < 490000 && message_pending_oe !== 1'b1; i++)
      @(negedge mclk);
    n = cyc - t0 - BOOT_MS * TICK_CYCLES;
    chk(n >= 0 && n <= 3, 1'b1);
    chk(message_pending_line_n, 1'b0);
    repeat (20) @(negedge mclk);
    chk(message_pending_oe, 1'b1);
    @(posedge mclk) ack_en <= 1'b1;
    repeat (4) @(negedge mclk);
    chk(message_pending_oe, 1'b0);
    @(posedge mclk) ack_en <= 1'b0;
  endtask
  task automatic t_touch();
    integ(n);
    chk(n, 3);
    @(posedge mclk) touch_x <= 8'h0a;
    repeat (3) @(negedge mclk);
    chk(report_touch, 1'b0);
    @(posedge mclk) touch_x <= 8'h64;
    repeat (3) @(negedge mclk);
    chk(report_touch, 1'b1);
    @(posedge mclk) mutual_signal[11:0] <= touch_threshold;
    n = n_acq;
    for (int i = 0; i < 30000 && n_acq == n; i++) @(negedge mclk);
    repeat (2) @(negedge mclk);
    chk(touched[0], 1'b0);
    integ(n);
    chk(n, 3);
    for (int i = 0; i < 20000 && active_mode !== 1'b1; i++) @(negedge mclk);
    chk(active_mode, 1'b1);
    period(TICK_CYCLES);
    @(posedge mclk) mutual_signal[11:0] <= 12'h000;
    for (int i = 0; i < 60000 && active_mode !== 1'b0; i++) @(negedge mclk);
    chk(active_mode, 1'b0);
    period(3 * TICK_CYCLES);
  endtask
  task automatic t_timeout();
    @(posedge mclk) auto <= 1'b0;
    rise();
    // A finished drive line restarts the per-line timer mid-burst.
    repeat (15000) @(negedge mclk);
    @(posedge mclk) acq_line_done <= 1'b1;
    @(posedge mclk) acq_line_done <= 1'b0;
    repeat (10000) @(negedge mclk);
    chk(signal_error_flag, 1'b0);
    for (int i = 0; i < 30000 && signal_error_flag !== 1'b1; i++)
      @(negedge mclk);
    chk(signal_error_flag, 1'b1);
    chk(burst_on, 1'b0);
    chk(message_pending_oe, 1'b1);
    @(posedge mclk) ack_en <= 1'b1;
    repeat (4) @(negedge mclk);
    chk(signal_error_flag, 1'b0);
    @(posedge mclk) ack_en <= 1'b0;
    auto <= 1'b1;
  endtask
  task automatic t_events();
    for (int k = 0; k < 5; k++) begin
      @(posedge mclk) trig <= 5'h01 << k;
      @(posedge mclk) trig <= 5'h00;
      @(negedge mclk) chk(recalibrate, 1'b1);
    end
    for (int k = 0; k < 3; k++) begin
      @(posedge mclk) nz <= 2'(k + 1);
      @(posedge mclk) nz <= 2'h0;
      @(negedge mclk) chk(noise_suppress, 1'b1);
      @(negedge mclk) chk(noise_suppress, 1'b0);
    end
    @(posedge mclk) {self_enable, moisture_comp_enable} <= 2'h3;
    mutual_moisture <= 1'b1;
    repeat (3) @(negedge mclk);
    chk({moisture_present, use_self_single}, 2'h3);
    @(posedge mclk) mutual_moisture <= 1'b0;
    for (int i = 0; i < 5 && recalibrate !== 1'b1; i++) @(negedge mclk);
    chk(recalibrate, 1'b1);
  endtask
  // Self data alone confirms a touch that mutual data misses.
  task automatic t_self();
    @(posedge mclk) self_touch <= 8'h02;
    for (int i = 0; i < 100000 && touched[1] !== 1'b1; i++) @(negedge mclk);
    chk(touched[1], 1'b1);
    @(posedge mclk) self_touch <= 8'h00;
  endtask

  // ==========================================================================
  // Main sequence and watchdog
  // ==========================================================================
  // Eight cycles of reset, then the scenarios in order.
  initial begin
    repeat (8) @(posedge mclk);
    rst <= 1'b0;
    t_boot();
    auto <= 1'b1;
    t_touch();
    t_timeout();
    t_events();
    t_self();
    results();
  end
  // Boot plus some twenty bursts fit inside this span.
  initial begin
    repeat (1000000) @(posedge mclk);
    bad_count++;
    results();
  end
endmodule // test_tac_ctrl
